// ==== ssr_defs.vh ====
`ifndef SSR_DEFS_VH
`define SSR_DEFS_VH
`define SSR_WIDTH       8
`define SSR_LAST        7
`define SSR_RESET_VAL   8'h00
`define SSR_SYNC_RESET  1'h0
`define SSR_PIN_COUNT   5
`define SSR_PIN_SER     0
`define SSR_PIN_SCLK    1
`define SSR_PIN_SCLR    2
`define SSR_PIN_RCLK    3
`define SSR_PIN_STORAGE_CLEAR_N    4
`endif

// ==== ssr_top.v ====
// Contract
// R1: eight-stage shift register feeds eight-bit storage
// R2: shift clear low zeroes all shift stages
// R3: rising shift clock shifts serial input in
// R4: falling shift clock changes nothing
// R5: storage clear low zeroes storage register
// R6: rising storage clock loads all shift stages
// R7: falling storage clock changes nothing
// R8: last shift stage drives cascade output
// R9: tied clocks: storage lags shift by one
// R10: parallel outputs always follow storage bits
`timescale 1ns/1ps
`include "ssr_defs.vh"
module ssr_top
(
    input  wire                     I_SYS_CLK,
    input  wire                     I_RESET_N,
    input  wire                     I_SERIAL_IN,
    input  wire                     I_SHIFT_CLOCK,
    input  wire                     I_SHIFT_CLEAR_N,
    input  wire                     I_STORAGE_CLOCK,
    input  wire                     I_STORAGE_CLEAR_N,
    output wire [`SSR_WIDTH-1:0]    O_PARALLEL_OUT,
    output wire                     O_CASCADE_OUT
);

    localparam [`SSR_WIDTH-1:0]     RESET_VAL = `SSR_RESET_VAL;

    // raw pins and their synchronised copies
    wire [`SSR_PIN_COUNT-1:0]       pin_raw;
    wire [`SSR_PIN_COUNT-1:0]       pin_sync;
    wire                            ser_s;
    wire                            sclk_s;
    wire                            sclr_n_s;
    wire                            rclk_s;
    wire                            storage_clear_n_n_s;

    // edge and clear requests
    wire                            shift_rise;
    wire                            store_rise;
    wire                            shift_clear;
    wire                            store_clear;
    reg                             shift_prev_r;
    reg                             shift_prev_nxt;
    reg                             store_prev_r;
    reg                             store_prev_nxt;

    // register contents
    wire [`SSR_WIDTH-1:0]           shift_q;
    wire [`SSR_WIDTH-1:0]           store_q;

    genvar                          p;
    genvar                          s;

    // high when a synced clock goes from low to high
    function rise_found;
        input                       cur;
        input                       prev;
        begin
            rise_found = cur & ~prev;
        end
    endfunction

    // active-low clear pin turned into an active-high request
    function clear_found;
        input                       level_n;
        begin
            clear_found = ~level_n;
        end
    endfunction

    // pin order is fixed by the position macros
    assign pin_raw[`SSR_PIN_SER]  = I_SERIAL_IN;
    assign pin_raw[`SSR_PIN_SCLK] = I_SHIFT_CLOCK;
    assign pin_raw[`SSR_PIN_SCLR] = I_SHIFT_CLEAR_N;
    assign pin_raw[`SSR_PIN_RCLK] = I_STORAGE_CLOCK;
    assign pin_raw[`SSR_PIN_STORAGE_CLEAR_N] = I_STORAGE_CLEAR_N;

    // two flip-flops per pin before any logic reads it
    generate
        for (p = 0; p < `SSR_PIN_COUNT; p = p + 1)
        begin : g_sync
            reg                     first_r;
            reg                     second_r;

            always @(posedge I_SYS_CLK)
            begin
                if (!I_RESET_N)
                begin
                    first_r  <= `SSR_SYNC_RESET;
                    second_r <= `SSR_SYNC_RESET;
                end
                else
                begin
                    first_r  <= pin_raw[p];
                    second_r <= first_r;
                end
            end

            assign pin_sync[p] = second_r;
        end
    endgenerate

    // synced levels by pin
    assign ser_s       = pin_sync[`SSR_PIN_SER];
    assign sclk_s      = pin_sync[`SSR_PIN_SCLK];
    assign sclr_n_s    = pin_sync[`SSR_PIN_SCLR];
    assign rclk_s      = pin_sync[`SSR_PIN_RCLK];
    assign storage_clear_n_n_s    = pin_sync[`SSR_PIN_STORAGE_CLEAR_N];

    // only rising edges act; falling edges are ignored
    assign shift_rise  = rise_found(sclk_s, shift_prev_r); // R3 R4
    assign store_rise  = rise_found(rclk_s, store_prev_r); // R6 R7
    assign shift_clear = clear_found(sclr_n_s); // R2
    assign store_clear = clear_found(storage_clear_n_n_s); // R5

    // last synced shift clock level, for edge finding
    always @*
    begin
        shift_prev_nxt = sclk_s;
    end

    always @(posedge I_SYS_CLK)
    begin
        if (!I_RESET_N)
            shift_prev_r <= `SSR_SYNC_RESET;
        else
            shift_prev_r <= shift_prev_nxt;
    end

    // last synced storage clock level, for edge finding
    always @*
    begin
        store_prev_nxt = rclk_s;
    end

    always @(posedge I_SYS_CLK)
    begin
        if (!I_RESET_N)
            store_prev_r <= `SSR_SYNC_RESET;
        else
            store_prev_r <= store_prev_nxt;
    end

    // one flip-flop per shift stage; stage 0 takes the serial input
    generate
        for (s = 0; s < `SSR_WIDTH; s = s + 1)
        begin : g_shift
            reg                     stage_r;
            reg                     stage_nxt;
            wire                    stage_in;

            if (s == 0)
            begin : g_head
                assign stage_in = ser_s; // R3
            end
            else
            begin : g_body
                assign stage_in = shift_q[s-1]; // R1 R3
            end

            always @*
            begin
                stage_nxt = stage_r;
                if (shift_clear)
                begin
                    stage_nxt = 1'h0; // R2
                end
                else if (shift_rise)
                begin
                    stage_nxt = stage_in; // R3
                end
            end

            always @(posedge I_SYS_CLK)
            begin
                if (!I_RESET_N)
                    stage_r <= RESET_VAL[s];
                else
                    stage_r <= stage_nxt;
            end

            assign shift_q[s] = stage_r;
        end
    endgenerate

    // storage stages load every shift stage at once; clear wins
    generate
        for (s = 0; s < `SSR_WIDTH; s = s + 1)
        begin : g_store
            reg                     stage_r;
            reg                     stage_nxt;
            wire                    stage_src;

            assign stage_src = shift_q[s]; // R1 R6

            always @*
            begin
                stage_nxt = stage_r;
                if (store_clear)
                begin
                    stage_nxt = 1'h0; // R5
                end
                else if (store_rise)
                begin
                    stage_nxt = stage_src; // R6 R9
                end
            end

            always @(posedge I_SYS_CLK)
            begin
                if (!I_RESET_N)
                    stage_r <= RESET_VAL[s];
                else
                    stage_r <= stage_nxt;
            end

            assign store_q[s] = stage_r;
        end
    endgenerate

    // data outputs straight from the flip-flops
    assign O_PARALLEL_OUT = store_q; // R10
    assign O_CASCADE_OUT  = shift_q[`SSR_LAST]; // R8
endmodule

// ==== ssr_top_sva.sv ====
`timescale 1ns/1ps
module ssr_top_sva
(
    input wire          I_SYS_CLK,
    input wire          I_RESET_N,
    input wire          I_SHIFT_CLOCK,
    input wire          I_SHIFT_CLEAR_N,
    input wire          I_STORAGE_CLOCK,
    input wire          I_STORAGE_CLEAR_N,
    input wire [7:0]    O_PARALLEL_OUT,
    input wire          O_CASCADE_OUT
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (!I_RESET_N);

    // pin edges with the matching clear released
    sequence shift_fall_s;
        $fell(I_SHIFT_CLOCK) && I_SHIFT_CLEAR_N;
    endsequence

    sequence store_fall_s;
        $fell(I_STORAGE_CLOCK) && I_STORAGE_CLEAR_N;
    endsequence

    sequence store_rise_s;
        $rose(I_STORAGE_CLOCK) && I_STORAGE_CLEAR_N;
    endsequence

    property shift_clear_p;
        (!I_SHIFT_CLEAR_N) [*4] |-> !O_CASCADE_OUT;
    endproperty

    property store_clear_p;
        (!I_STORAGE_CLEAR_N) [*4] |-> (O_PARALLEL_OUT == 8'h00);
    endproperty

    property shift_hold_p;
        shift_fall_s |-> ##1 ($stable(O_CASCADE_OUT)) [*4];
    endproperty

    property store_hold_p;
        store_fall_s |-> ##1 ($stable(O_PARALLEL_OUT)) [*4];
    endproperty

    // the load takes the shift contents from before a tied shift
    property store_load_p;
        store_rise_s |-> ##3 (O_PARALLEL_OUT[7] == $past(O_CASCADE_OUT));
    endproperty

    property cascade_change_p;
        $changed(O_CASCADE_OUT) |->
            ($past(I_SHIFT_CLOCK, 3) && !$past(I_SHIFT_CLOCK, 4)) || !$past(I_SHIFT_CLEAR_N, 3);
    endproperty

    property parallel_change_p;
        $changed(O_PARALLEL_OUT) |->
            ($past(I_STORAGE_CLOCK, 3) && !$past(I_STORAGE_CLOCK, 4)) || !$past(I_STORAGE_CLEAR_N, 3);
    endproperty

    shift_clear_a: assert property (shift_clear_p) else $error("shift clear left cascade high");
    store_clear_a: assert property (store_clear_p) else $error("storage clear left outputs set");
    shift_hold_a: assert property (shift_hold_p) else $error("falling shift clock moved data");
    store_hold_a: assert property (store_hold_p) else $error("falling storage clock moved data");
    store_load_a: assert property (store_load_p) else $error("storage load took wrong data");
    cascade_change_a: assert property (cascade_change_p) else $error("cascade changed unasked");
    parallel_change_a: assert property (parallel_change_p) else $error("outputs changed unasked");
endmodule

bind ssr_top ssr_top_sva u_ssr_top_sva
(
    .I_SYS_CLK          (I_SYS_CLK),
    .I_RESET_N          (I_RESET_N),
    .I_SHIFT_CLOCK      (I_SHIFT_CLOCK),
    .I_SHIFT_CLEAR_N    (I_SHIFT_CLEAR_N),
    .I_STORAGE_CLOCK    (I_STORAGE_CLOCK),
    .I_STORAGE_CLEAR_N  (I_STORAGE_CLEAR_N),
    .O_PARALLEL_OUT     (O_PARALLEL_OUT),
    .O_CASCADE_OUT      (O_CASCADE_OUT)
);

// ==== ssr_host.sv ====
`timescale 1ns/1ps
module ssr_host
(
    output reg          o_serial_in = 1'h0,
    output wire         o_shift_clock,
    output wire         o_shift_clear_n,
    output wire         o_storage_clock,
    output wire         o_storage_clear_n
);
    // shift clock, shift clear, storage clock, storage clear; idle is clocks low
    reg [3:0]           pins = 4'h5;

    assign {o_shift_clock, o_shift_clear_n, o_storage_clock, o_storage_clear_n} = pins;

    // one 125 ns link period: idle half, then the asked pins
    task tick(input [3:0] v);
    begin
        pins <= 4'h5;
        #62.5;
        pins <= v;
        #62.5;
    end
    endtask

    // first bit sent ends in the last stage; data changes while clocks are low
    task send(input [7:0] b, input [3:0] v);
        integer i;
    begin
        for (i = 7; i >= 0; i = i - 1)
        begin
            o_serial_in <= b[i];
            tick(v);
        end
    end
    endtask
endmodule

// ==== test_serial_shift_storage_register.sv ====
`timescale 1ns/1ps
module test_serial_shift_storage_register;
    reg                 sys_clk = 1'h0;
    reg                 reset_n = 1'h0;
    wire                serial_in;
    wire                shift_clock;
    wire                shift_clear_n;
    wire                storage_clock;
    wire                storage_clear_n;
    wire                cascade_out;
    wire [7:0]          parallel_out;
    integer             fail_count = 0;
    integer             checks_done = 0;

    ssr_host h
    (
        .o_serial_in        (serial_in),
        .o_shift_clock      (shift_clock),
        .o_shift_clear_n    (shift_clear_n),
        .o_storage_clock    (storage_clock),
        .o_storage_clear_n  (storage_clear_n)
    );

    ssr_top dut
    (
        .I_SYS_CLK          (sys_clk),
        .I_RESET_N          (reset_n),
        .I_SERIAL_IN        (serial_in),
        .I_SHIFT_CLOCK      (shift_clock),
        .I_SHIFT_CLEAR_N    (shift_clear_n),
        .I_STORAGE_CLOCK    (storage_clock),
        .I_STORAGE_CLEAR_N  (storage_clear_n),
        .O_PARALLEL_OUT     (parallel_out),
        .O_CASCADE_OUT      (cascade_out)
    );

    initial
    begin
        forever #4 sys_clk = ~sys_clk;
    end

    task chk(input string name, input [7:0] exp_v, input [7:0] seen_v);
    begin
        checks_done = checks_done + 1;
        if (seen_v !== exp_v)
        begin
            fail_count = fail_count + 1;
            $display("unexpected %s expected %h seen %h", name, exp_v, seen_v);
        end
    end
    endtask

    task summarize;
    begin
        if (fail_count == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask

    // shift a byte in, then load it with the storage clock alone
    task test_shift_store;
    begin
        h.send(8'hA5, 4'hD);
        chk("cascade_out", 8'h01, {7'h00, cascade_out});
        chk("parallel_out", 8'h00, parallel_out);
        h.tick(4'h7);
        chk("parallel_out", 8'hA5, parallel_out);
    end
    endtask

    // shift clear leaves storage alone; storage clear then zeroes the outputs
    task test_clears;
    begin
        h.tick(4'h1);
        chk("cascade_out", 8'h00, {7'h00, cascade_out});
        chk("parallel_out", 8'hA5, parallel_out);
        h.tick(4'h4);
        chk("parallel_out", 8'h00, parallel_out);
    end
    endtask

    // tied clocks: storage holds the contents before the last shift
    task test_tied;
    begin
        h.send(8'h3C, 4'hF);
        chk("parallel_out", 8'h1E, parallel_out);
        chk("cascade_out", 8'h00, {7'h00, cascade_out});
        h.tick(4'h5);
        chk("parallel_out", 8'h1E, parallel_out);
        chk("cascade_out", 8'h00, {7'h00, cascade_out});
    end
    endtask

    // about 2500 ns of tests; give it ample room
    initial
    begin
        #10000;
        fail_count = fail_count + 1;
        summarize;
    end

    initial
    begin
        repeat (4) @(posedge sys_clk);
        reset_n <= 1'h1;
        repeat (4) @(posedge sys_clk);
        test_shift_store;
        test_clears;
        test_tied;
        summarize;
    end
endmodule
